// File: design/sdmb_sdram.v
// Synchronous DRAM device: command decode, mode, bursts, read latency
`timescale 1ns/10ps
`include "sdmb_defs.vh"

module sdmb_sdram (
  input  wire         sys_clk_in,
  input  wire         resetn_in,
  input  wire         cs_n_in,
  input  wire         ras_n_in,
  input  wire         cas_n_in,
  input  wire         we_n_in,
  input  wire         bank_select_low_in,
  input  wire         bank_select_high_in,
  input  wire [11:0]  row_address_bits_in,
  input  wire [15:0]  dq_in,
  output wire [15:0]  dq_out,
  output wire         dq_oe_out,
  output wire         wr_buf_ready_out
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  reg  [`SDMB_DATA_W-1:0]  mem [0:`SDMB_WORDS-1];
  reg  [`SDMB_ROW_W-1:0]   open_row_reg [0:3];
  reg  [3:0]               row_open_reg;
  reg  [`SDMB_MODE_W-1:0]  mode_reg;
  reg                      bst_active_reg;
  reg                      bst_write_reg;
  reg  [7:0]               bst_step_reg;
  reg  [7:0]               bst_start_reg;
  reg  [1:0]               bst_bank_reg;
  reg                      fetch_vld_reg;
  reg  [`SDMB_IDX_W-1:0]   fetch_idx_reg;
  reg                      stage_vld_reg;
  reg  [`SDMB_DATA_W-1:0]  stage_data_reg;
  reg  [`SDMB_DATA_W-1:0]  dq_out_reg;
  reg                      dq_oe_reg;
  wire [3:0]               cmd;
  wire [1:0]               bank;
  wire                     is_lmr;
  wire                     is_act;
  wire                     is_rd;
  wire                     is_wr;
  wire                     is_pre;
  wire                     is_bst;
  wire                     op_normal;
  wire                     lat2;
  wire                     new_burst;
  wire                     stop_cmd;
  wire                     cur_valid;
  wire                     cur_write;
  wire [7:0]               cur_start;
  wire [7:0]               cur_step;
  wire [1:0]               cur_bank;
  wire [7:0]               cur_col;
  wire                     cur_last;
  wire [`SDMB_IDX_W-1:0]   cur_idx;
  wire [`SDMB_DATA_W-1:0]  rd_word;
  wire                     wb_in_ready;
  wire                     wb_out_valid;
  wire                     wb_out_ready;
  wire [`SDMB_IDX_W+`SDMB_DATA_W-1:0] wb_out_data;

  // Flat word index from bank, row and column
  function [`SDMB_IDX_W-1:0] sdmb_index;
    input [1:0]  b;
    input [11:0] r;
    input [7:0]  c;
    begin
      sdmb_index = {b, r, c};
    end
  endfunction

  // --------------------------------------------------------------
  // Command decode
  // --------------------------------------------------------------
  assign cmd       = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  assign bank      = {bank_select_high_in, bank_select_low_in};
  assign is_lmr    = (cmd == `SDMB_CMD_LMR);
  assign is_act    = (cmd == `SDMB_CMD_ACT);
  assign is_rd     = (cmd == `SDMB_CMD_RD);
  assign is_wr     = (cmd == `SDMB_CMD_WR);
  assign is_pre    = (cmd == `SDMB_CMD_PRE);
  assign is_bst    = (cmd == `SDMB_CMD_BST);

  // Mode fields
  assign op_normal = (mode_reg[`SDMB_OP_MSB:`SDMB_OP_LSB] == `SDMB_OP_NORMAL);
  assign lat2      = (mode_reg[`SDMB_CL_MSB:`SDMB_CL_LSB] == `SDMB_CL_2);

  // --------------------------------------------------------------
  // Burst sequencing
  // --------------------------------------------------------------
  // A new burst needs an open row in the addressed bank
  assign new_burst = (is_rd | is_wr) & row_open_reg[bank] & op_normal;
  // Any column command, stop or precharge ends the running burst
  assign stop_cmd  = is_rd | is_wr | is_bst | is_pre;
  assign cur_valid = new_burst | (bst_active_reg & ~stop_cmd);
  assign cur_write = new_burst ? is_wr : bst_write_reg;
  assign cur_start = new_burst ? row_address_bits_in[7:0] : bst_start_reg;
  assign cur_step  = new_burst ? 8'h00 : bst_step_reg;
  assign cur_bank  = new_burst ? bank : bst_bank_reg;

  sdmb_burst_addr u_addr (
    .start_col_in (cur_start),
    .step_in      (cur_step),
    .len_code_in  (mode_reg[`SDMB_BL_MSB:`SDMB_BL_LSB]),
    .order_in     (mode_reg[`SDMB_BT_BIT]),
    .col_out      (cur_col),
    .last_out     (cur_last)
  );

  assign cur_idx = sdmb_index(cur_bank, open_row_reg[cur_bank], cur_col);

  // Mode register, row state and burst counter
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg        <= `SDMB_MODE_RST;
      row_open_reg    <= 4'h0;
      open_row_reg[0] <= 12'h000;
      open_row_reg[1] <= 12'h000;
      open_row_reg[2] <= 12'h000;
      open_row_reg[3] <= 12'h000;
      bst_active_reg  <= 1'b0;
      bst_write_reg   <= 1'b0;
      bst_step_reg    <= 8'h00;
      bst_start_reg   <= 8'h00;
      bst_bank_reg    <= 2'h0;
    end else begin
      if (is_lmr) begin
        mode_reg <= {bank, row_address_bits_in};
      end
      if (is_act) begin
        row_open_reg[bank] <= 1'b1;
        open_row_reg[bank] <= row_address_bits_in;
      end
      if (is_pre) begin
        if (row_address_bits_in[`SDMB_AP_BIT]) begin
          row_open_reg <= 4'h0;
        end else begin
          row_open_reg[bank] <= 1'b0;
        end
      end
      bst_active_reg <= cur_valid & ~cur_last;
      bst_step_reg   <= cur_step + 8'h01;
      if (new_burst) begin
        bst_write_reg <= is_wr;
        bst_start_reg <= row_address_bits_in[7:0];
        bst_bank_reg  <= bank;
      end
    end
  end

  // --------------------------------------------------------------
  // Write path through buffer
  // --------------------------------------------------------------
  sdmb_fifo #(
    .W  (`SDMB_IDX_W + `SDMB_DATA_W),
    .D  (`SDMB_FIFO_DEPTH),
    .AW (`SDMB_FIFO_AW)
  ) u_wbuf (
    .sys_clk_in    (sys_clk_in),
    .resetn_in     (resetn_in),
    .in_valid_in   (cur_valid & cur_write),
    .in_ready_out  (wb_in_ready),
    .in_data_in    ({cur_idx, dq_in}),
    .out_valid_out (wb_out_valid),
    .out_ready_in  (wb_out_ready),
    .out_data_out  (wb_out_data)
  );

  // Array port goes to reads first, buffer drains in free cycles
  assign wb_out_ready     = ~fetch_vld_reg;
  assign wr_buf_ready_out = wb_in_ready;

  // Array write from buffer
  always @(posedge sys_clk_in) begin
    if (wb_out_valid & wb_out_ready) begin
      mem[wb_out_data[`SDMB_IDX_W+`SDMB_DATA_W-1:`SDMB_DATA_W]] <= wb_out_data[`SDMB_DATA_W-1:0];
    end
  end

  // --------------------------------------------------------------
  // Read pipeline and data pins
  // --------------------------------------------------------------
  assign rd_word = mem[fetch_idx_reg];

  // Fetch at command edge, word on pins after edge n+m-1
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      fetch_vld_reg  <= 1'b0;
      fetch_idx_reg  <= {`SDMB_IDX_W{1'b0}};
      stage_vld_reg  <= 1'b0;
      stage_data_reg <= 16'h0000;
      dq_out_reg     <= 16'h0000;
      dq_oe_reg      <= 1'b0;
    end else begin
      fetch_vld_reg  <= cur_valid & ~cur_write;
      fetch_idx_reg  <= cur_idx;
      stage_vld_reg  <= fetch_vld_reg;
      stage_data_reg <= rd_word;
      if (lat2) begin
        dq_oe_reg  <= fetch_vld_reg;
        dq_out_reg <= rd_word;
      end else begin
        dq_oe_reg  <= stage_vld_reg;
        dq_out_reg <= stage_data_reg;
      end
    end
  end

  assign dq_out    = dq_out_reg;
  assign dq_oe_out = dq_oe_reg;

endmodule

// File: pkg/sdmb_defs.vh
// Constants shared by the synchronous DRAM device model
`ifndef SDMB_DEFS_VH
`define SDMB_DEFS_VH

// --------------------------------------------------------------
// Command codes as {chip select, row strobe, column strobe, write}
// --------------------------------------------------------------
`define SDMB_CMD_LMR      4'h0
`define SDMB_CMD_REF      4'h1
`define SDMB_CMD_PRE      4'h2
`define SDMB_CMD_ACT      4'h3
`define SDMB_CMD_WR       4'h4
`define SDMB_CMD_RD       4'h5
`define SDMB_CMD_BST      4'h6

// --------------------------------------------------------------
// Array geometry
// --------------------------------------------------------------
`define SDMB_BANK_W       2
`define SDMB_ROW_W        12
`define SDMB_COL_W        8
`define SDMB_DATA_W       16
`define SDMB_IDX_W        22
`define SDMB_WORDS        4194304
`define SDMB_AP_BIT       10

// --------------------------------------------------------------
// Operating mode configuration fields and encodings
// --------------------------------------------------------------
`define SDMB_MODE_W       14
`define SDMB_MODE_RST     14'h0000
`define SDMB_BL_MSB       2
`define SDMB_BL_LSB       0
`define SDMB_BT_BIT       3
`define SDMB_CL_MSB       6
`define SDMB_CL_LSB       4
`define SDMB_OP_MSB       8
`define SDMB_OP_LSB       7
`define SDMB_RSV_MSB      13
`define SDMB_RSV_LSB      9
`define SDMB_BL_1         3'h0
`define SDMB_BL_2         3'h1
`define SDMB_BL_4         3'h2
`define SDMB_BL_8         3'h3
`define SDMB_BL_FULL      3'h7
`define SDMB_BT_SEQ       1'h0
`define SDMB_BT_INTLV     1'h1
`define SDMB_CL_2         3'h2
`define SDMB_CL_3         3'h3
`define SDMB_OP_NORMAL    2'h0

// --------------------------------------------------------------
// Write buffer
// --------------------------------------------------------------
`define SDMB_FIFO_DEPTH   8
`define SDMB_FIFO_AW      3

`endif

// File: design/sdmb_fifo.v
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/10ps
module sdmb_fifo #(
  parameter W  = 38,
  parameter D  = 8,
  parameter AW = 3
) (
  input  wire          sys_clk_in,
  input  wire          resetn_in,
  input  wire          in_valid_in,
  output wire          in_ready_out,
  input  wire [W-1:0]  in_data_in,
  output wire          out_valid_out,
  input  wire          out_ready_in,
  output wire [W-1:0]  out_data_out
);

  localparam [AW:0] FULL_CNT = D[AW:0];

  reg  [W-1:0]  buf_mem [0:D-1];
  reg  [AW-1:0] wr_ptr_reg;
  reg  [AW-1:0] rd_ptr_reg;
  reg  [AW:0]   count_reg;
  reg  [AW:0]   count_next;
  reg           ready_reg;
  reg           valid_reg;
  wire          push;
  wire          pop;

  // --------------------------------------------------------------
  // Handshakes
  // --------------------------------------------------------------
  assign push          = in_valid_in & ready_reg;
  assign pop           = out_ready_in & valid_reg;
  assign in_ready_out  = ready_reg;
  assign out_valid_out = valid_reg;
  assign out_data_out  = buf_mem[rd_ptr_reg];

  // Occupancy after this edge
  always @* begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + 1'b1;
    end else if (pop & ~push) begin
      count_next = count_reg - 1'b1;
    end
  end

  // Pointers and flags
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
      ready_reg  <= 1'b1;
      valid_reg  <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_next;
      ready_reg <= (count_next != FULL_CNT);
      valid_reg <= (count_next != {(AW+1){1'b0}});
    end
  end

  // Storage
  always @(posedge sys_clk_in) begin
    if (push) begin
      buf_mem[wr_ptr_reg] <= in_data_in;
    end
  end

endmodule

// File: design/sdmb_burst_addr.v
// Column address of one step of a burst
`timescale 1ns/10ps
`include "sdmb_defs.vh"
module sdmb_burst_addr (
  input  wire [7:0]  start_col_in,
  input  wire [7:0]  step_in,
  input  wire [2:0]  len_code_in,
  input  wire        order_in,
  output wire [7:0]  col_out,
  output wire        last_out
);

  wire       full_page;
  wire       intlv;
  wire [7:0] mask;
  wire [7:0] offs;

  // Block mask from length code, reserved codes act as length one
  function [7:0] sdmb_len_mask;
    input [2:0] code;
    begin
      case (code)
        `SDMB_BL_2:    sdmb_len_mask = 8'h01;
        `SDMB_BL_4:    sdmb_len_mask = 8'h03;
        `SDMB_BL_8:    sdmb_len_mask = 8'h07;
        `SDMB_BL_FULL: sdmb_len_mask = 8'hFF;
        default:       sdmb_len_mask = 8'h00;
      endcase
    end
  endfunction

  // --------------------------------------------------------------
  // Wrap within aligned block
  // --------------------------------------------------------------
  assign full_page = (len_code_in == `SDMB_BL_FULL);
  assign mask      = sdmb_len_mask(len_code_in);
  assign intlv     = (order_in == `SDMB_BT_INTLV) & ~full_page;
  assign offs      = intlv ? (start_col_in ^ step_in)
                           : (start_col_in + step_in);
  assign col_out   = (start_col_in & ~mask) | (offs & mask);
  assign last_out  = ~full_page & (step_in == mask);

endmodule

// File: verification/sdmb_sdram_assertions.sv
// Checker for read timing, burst length and refused reads of the DRAM device
`timescale 1ns/10ps
`include "sdmb_defs.vh"
module sdmb_sdram_chk (
  input wire        sys_clk_in,
  input wire        resetn_in,
  input wire        cs_n_in,
  input wire        ras_n_in,
  input wire        cas_n_in,
  input wire        we_n_in,
  input wire        bank_select_low_in,
  input wire        bank_select_high_in,
  input wire [11:0] row_address_bits_in,
  input wire        dq_oe_out
);
  reg  [13:0] mode_reg;
  reg  [3:0]  open_reg;
  wire [3:0]  cmd   = {cs_n_in, ras_n_in, cas_n_in, we_n_in};
  wire [1:0]  bank  = {bank_select_high_in, bank_select_low_in};
  wire        rd    = cmd == `SDMB_CMD_RD;
  wire        rd_ok = rd && open_reg[bank] && mode_reg[8:7] == 2'h0;
  wire        cl2   = mode_reg[6:4] == `SDMB_CL_2;
  wire        quiet = !(rd || cmd == `SDMB_CMD_WR || cmd == `SDMB_CMD_BST || cmd == `SDMB_CMD_PRE);
  // Mirror of mode value and open rows
  always @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mode_reg <= 14'h0000;
      open_reg <= 4'h0;
    end else if (cmd == `SDMB_CMD_LMR) begin
      mode_reg <= {bank, row_address_bits_in};
    end else if (cmd == `SDMB_CMD_ACT) begin
      open_reg[bank] <= 1'b1;
    end else if (cmd == `SDMB_CMD_PRE) begin
      open_reg <= row_address_bits_in[10] ? 4'h0 : open_reg & ~(4'h1 << bank);
    end
  end
  // --------------------------------------------------------------
  // Properties
  // --------------------------------------------------------------
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  AST_LAT2: assert property (rd_ok && cl2 |-> ##2 dq_oe_out)
    else $error("no read data two clocks after read");
  AST_LAT3: assert property (rd_ok && !cl2 |-> ##3 dq_oe_out)
    else $error("no read data three clocks after read");
  AST_ROSE_CAUSE: assert property ($rose(dq_oe_out) |-> $past(rd_ok, 2) || $past(rd_ok, 3))
    else $error("data driven without accepted read");
  AST_NO_ROW: assert property ((rd && !open_reg[bank]) ##1 quiet [*3] |-> ##1 !dq_oe_out)
    else $error("read without open row drove data");
  AST_TEST_MODE: assert property ((rd && mode_reg[8:7] != 2'h0) ##1 quiet [*3] |-> ##1 !dq_oe_out [*2])
    else $error("read in test mode drove data");
  AST_LEN4: assert property ((rd_ok && cl2 && mode_reg[2:0] == `SDMB_BL_4) ##1 quiet [*4]
    |-> ##1 dq_oe_out ##1 !dq_oe_out)
    else $error("length four burst wrong length");
  AST_LEN1: assert property ((rd_ok && !cl2 && mode_reg[2:0] == `SDMB_BL_1) ##1 quiet [*3]
    |-> ##1 (!dq_oe_out && $past(dq_oe_out)))
    else $error("length one burst wrong length");
  AST_FULL_RUN: assert property ((rd_ok && cl2 && mode_reg[2:0] == `SDMB_BL_FULL) ##1 quiet [*8]
    |-> dq_oe_out)
    else $error("full page burst stopped early");
  COV_INTLV: cover property (rd_ok && mode_reg[3]);
  COV_FULL: cover property (rd_ok && mode_reg[2:0] == `SDMB_BL_FULL);
  COV_NO_ROW: cover property (rd && !open_reg[bank]);
endmodule

bind sdmb_sdram sdmb_sdram_chk u_chk (.sys_clk_in, .resetn_in, .cs_n_in, .ras_n_in, .cas_n_in,
  .we_n_in, .bank_select_low_in, .bank_select_high_in, .row_address_bits_in, .dq_oe_out);

// File: verification/sdmb_ctrl_model.sv
// Memory controller model driving command, address and write data pins
`timescale 1ns/10ps
`include "sdmb_defs.vh"
module sdmb_ctrl_model (
  input  wire        sys_clk_in,
  output reg  [3:0]  cmd_n_out,
  output reg  [1:0]  bank_out,
  output reg  [11:0] addr_out,
  output reg  [15:0] dq_out
);
  // Idle pins at time zero
  initial begin
    cmd_n_out = 4'hF;
    bank_out = 2'h0;
    addr_out = 12'h000;
    dq_out = 16'h0000;
  end
  // --------------------------------------------------------------
  // Command tasks
  // --------------------------------------------------------------
  // One command per edge, changed just after the edge
  task drv(input [3:0] c, input [1:0] b, input [11:0] a, input [15:0] d);
    begin
      @(posedge sys_clk_in);
      cmd_n_out <= c;
      bank_out <= b;
      addr_out <= a;
      dq_out <= d;
    end
  endtask
  // Data lines not in use show the inverse of the last value
  task cmd(input [3:0] c, input [1:0] b, input [11:0] a);
    drv(c, b, a, ~dq_out);
  endtask
  task idle(input integer n);
    repeat (n) cmd(4'hF, 2'h0, 12'h000);
  endtask
  // Precharge all, optional double refresh, load mode, then wait
  task load(input [11:0] m, input r);
    begin
      cmd(`SDMB_CMD_PRE, 2'h0, 12'h400);
      if (r) begin
        cmd(`SDMB_CMD_REF, 2'h0, 12'h000);
        idle(1);
        cmd(`SDMB_CMD_REF, 2'h0, 12'h000);
      end
      idle(1);
      cmd(`SDMB_CMD_LMR, 2'h0, m);
      idle(2);
    end
  endtask
  // Power-up wait of 100 us, then mode load before any access
  task init(input [11:0] m);
    begin
      idle(1000);
      load(m, 1'b1);
    end
  endtask
endmodule

// File: verification/tb_sdram_mode_burst_init.sv
// Testbench for the DRAM device: mode, burst order, latency, refusals
`timescale 1ns/10ps
`include "sdmb_defs.vh"
module tb_sdram_mode_burst_init;
  reg          sys_clk_in = 1'b0;
  reg          resetn_in  = 1'b0;
  wire [3:0]   cmd_n;
  wire [1:0]   ba;
  wire [11:0]  addr;
  wire [15:0]  dq_wr;
  wire [15:0]  dq_rd;
  wire         dq_oe;
  wire         wbr;
  reg  [15:0]  cap[$];
  integer      miscompares = 0;
  integer      checks = 0;
  integer      cyc = 0;
  integer      rd_cyc = 0;
  integer      first_cyc = 0;
  always #50 sys_clk_in = ~sys_clk_in;
  sdmb_sdram DUT (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .cs_n_in(cmd_n[3]),
    .ras_n_in(cmd_n[2]), .cas_n_in(cmd_n[1]), .we_n_in(cmd_n[0]), .bank_select_low_in(ba[0]),
    .bank_select_high_in(ba[1]), .row_address_bits_in(addr), .dq_in(dq_wr), .dq_out(dq_rd),
    .dq_oe_out(dq_oe), .wr_buf_ready_out(wbr));
  sdmb_ctrl_model ctl (.sys_clk_in(sys_clk_in), .cmd_n_out(cmd_n), .bank_out(ba), .addr_out(addr),
    .dq_out(dq_wr));
  // Record read edges and every driven word at the sampling edge
  always @(posedge sys_clk_in) begin
    cyc = cyc + 1;
    if (cmd_n == `SDMB_CMD_RD) rd_cyc = cyc;
    if (dq_oe === 1'b1) begin
      if (cap.size() == 0) first_cyc = cyc;
      cap.push_back(dq_rd);
    end
  end
  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task stop_test;
    begin
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  function [15:0] pat(input [1:0] b, input [7:0] c);
    pat = {b, 6'h2A, c};
  endfunction
  // Mode load with rows reopened in banks 2 and 1
  task set_mode(input [11:0] m);
    begin
      ctl.load(m, 1'b0);
      ctl.cmd(`SDMB_CMD_ACT, 2'h2, 12'hABC);
      ctl.cmd(`SDMB_CMD_ACT, 2'h1, 12'h5A3);
      ctl.idle(2);
    end
  endtask
  // Sequential write burst, stopped after n words when full page
  task wr(input [1:0] b, input [7:0] s, input integer n, input full);
    integer k;
    begin
      ctl.drv(`SDMB_CMD_WR, b, {4'h0, s}, pat(b, s));
      for (k = 1; k < n; k = k + 1) ctl.drv(4'hF, 2'h0, 12'h000, pat(b, s + k));
      if (full) ctl.cmd(`SDMB_CMD_BST, 2'h0, 12'h000);
      ctl.idle(12);
      @(negedge sys_clk_in);
      cmp({15'h0000, wbr}, 16'h0001);
    end
  endtask
  // Read burst and judge count, latency and column order
  task rd_chk(input [1:0] b, input [7:0] s, input integer n, input integer len, input bt, input integer cl);
    integer k;
    integer m;
    integer off;
    begin
      cap.delete();
      ctl.cmd(`SDMB_CMD_RD, b, {4'h0, s});
      if (len == 256) begin
        ctl.idle(n - 1);
        ctl.cmd(`SDMB_CMD_BST, 2'h0, 12'h000);
      end
      ctl.idle(12);
      m = len - 1;
      off = s & m;
      cmp(cap.size(), n);
      if (n > 0) cmp(first_cyc - rd_cyc, cl);
      for (k = 0; k < n; k = k + 1) cmp(cap[k], pat(b, (s & ~m) | ((bt ? off ^ k : off + k) & m)));
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task t_init;
    begin
      ctl.init(12'h033);
      set_mode(12'h033);
    end
  endtask
  // Two banks, length eight block and a full page write wrapping the row
  task t_write;
    begin
      wr(2'h2, 8'h10, 8, 1'b0);
      set_mode(12'h027);
      wr(2'h1, 8'hFE, 10, 1'b1);
      rd_chk(2'h1, 8'hFE, 10, 256, 1'b0, 2);
    end
  endtask
  task t_modes;
    integer lc;
    integer bt;
    integer cl;
    begin
      for (lc = 0; lc < 4; lc = lc + 1)
        for (bt = 0; bt < 2; bt = bt + 1)
          for (cl = 2; cl < 4; cl = cl + 1) begin
            set_mode({5'h00, cl[2:0], bt[0], lc[2:0]});
            rd_chk(2'h2, 8'h13, 1 << lc, 1 << lc, bt[0], cl);
          end
      set_mode(12'h005);
      rd_chk(2'h2, 8'h13, 1, 1, 1'b0, 3);
    end
  endtask
  // Read of a closed bank and read in a test mode give no data
  task t_refuse;
    begin
      rd_chk(2'h3, 8'h13, 0, 1, 1'b0, 3);
      set_mode(12'h0A0);
      rd_chk(2'h2, 8'h13, 0, 1, 1'b0, 2);
    end
  endtask
  // Mode survives refresh and a single bank precharge
  task t_hold;
    begin
      set_mode(12'h021);
      ctl.cmd(`SDMB_CMD_REF, 2'h0, 12'h000);
      ctl.cmd(`SDMB_CMD_PRE, 2'h1, 12'h000);
      ctl.idle(2);
      rd_chk(2'h2, 8'h13, 2, 2, 1'b0, 2);
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    t_init;
    t_write;
    t_modes;
    t_refuse;
    t_hold;
    stop_test;
  end
  // Watchdog
  initial begin
    #500000;
    miscompares = miscompares + 1;
    stop_test;
  end
endmodule
